// File: src/flash_ctrl_pkg.sv
/*
 * constants for the flash control block: register map, field positions,
 * reset values, command codes, protection range tables.
 * assumes a 16-bit flash address space with the array at the top half.
 */
package flash_ctrl_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int OFS_W = 8;

    localparam logic [OFS_W-1:0] OFS_CONFIG = 8'h00;
    localparam logic [OFS_W-1:0] OFS_PROT = 8'h04;
    localparam logic [OFS_W-1:0] OFS_STATUS = 8'h08;
    localparam logic [OFS_W-1:0] OFS_CMD = 8'h0C;
    localparam logic [OFS_W-1:0] OFS_ADDR = 8'h10;
    localparam logic [OFS_W-1:0] OFS_DATA = 8'h14;
    localparam logic [OFS_W-1:0] OFS_ARRAY_WR = 8'h18;
    localparam logic [OFS_W-1:0] OFS_SEC = 8'h1C;
    localparam logic [OFS_W-1:0] OFS_FACTORY = 8'h20;

    // config register
    localparam int BIT_BUF_EMPTY_IE = 7;
    localparam int BIT_CMD_DONE_IE = 6;
    // status register
    localparam int BIT_BUF_EMPTY = 7;
    localparam int BIT_CMD_DONE = 6;
    localparam int BIT_PROTECT_VIOLATION_FLAG = 5;
    // protection byte
    localparam int BIT_POLARITY = 7;
    localparam int BIT_SPARE = 6;
    localparam int BIT_UP_DIS = 5;
    localparam int BIT_UP_SIZE_HI = 4;
    localparam int BIT_UP_SIZE_LO = 3;
    localparam int BIT_LO_DIS = 2;
    localparam int BIT_LO_SIZE_HI = 1;
    localparam int BIT_LO_SIZE_LO = 0;

    localparam logic [7:0] PROT_RST = 8'hFF;
    localparam logic [7:0] SEC_RST = 8'hFF;
    localparam logic [7:0] CMD_RST = 8'h00;

    localparam logic [ADDR_W-1:0] FLASH_LO = 16'h8000;
    localparam logic [ADDR_W-1:0] PROT_BYTE_ADDR = 16'hFF0D;
    localparam logic [ADDR_W-1:0] SEC_BYTE_ADDR = 16'hFF0F;
    localparam logic [ADDR_W-1:0] SECTOR_MASK = 16'hFE00;

    localparam logic [7:0] CMD_PROGRAM = 8'h20;
    localparam logic [7:0] CMD_SECT_ERASE = 8'h40;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h41;

    // upper range start address and lower range end address by size code
    localparam logic [3:0][ADDR_W-1:0] UP_BASE = {
        16'hC000, 16'hE000, 16'hF000, 16'hF800};
    localparam logic [3:0][ADDR_W-1:0] LO_END = {
        16'h8FFF, 16'h87FF, 16'h83FF, 16'h81FF};

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_LOAD_PROT = 2'b01,
        ST_LOAD_SEC = 2'b11,
        ST_RUN = 2'b10
    } seq_state_t;
endpackage : flash_ctrl_pkg

// File: src/prot_check_if.sv
/*
 * carrier between the control block and its protection checker.
 * assumes both ends run on the same clock; the check is combinational.
 */
`timescale 1ns/100ps
`default_nettype none
interface prot_check_if;
    logic [7:0] cfg;
    logic [15:0] addr;
    logic mass;
    logic viol;
    modport requester (output cfg, output addr, output mass, input viol);
    modport judge (input cfg, input addr, input mass, output viol);
endinterface : prot_check_if
`default_nettype wire

// File: src/flash_prot_check.sv
/*
 * protection checker: decides whether a program or erase at an address
 * would touch a protected area, given the protection byte.
 * assumes the address is already inside the flash array.
 */
`timescale 1ns/100ps
`default_nettype none
module flash_prot_check
    import flash_ctrl_pkg::*;
(
    prot_check_if.judge chk
);
    logic upHit;
    logic loHit;
    logic rangeSel;
    logic isProt;

    always_comb begin
        upHit = chk.addr >= UP_BASE[chk.cfg[BIT_UP_SIZE_HI:BIT_UP_SIZE_LO]];
        loHit = chk.addr <= LO_END[chk.cfg[BIT_LO_SIZE_HI:BIT_LO_SIZE_LO]];
        // a range takes part only while its disable bit is clear
        rangeSel = (upHit && !chk.cfg[BIT_UP_DIS])
            || (loHit && !chk.cfg[BIT_LO_DIS]); // RULE16 RULE18
        // polarity swaps selected ranges between protected and unprotected
        isProt = chk.cfg[BIT_POLARITY] ? rangeSel : !rangeSel; // RULE14
        if (chk.mass) begin
            chk.viol = !(chk.cfg[BIT_POLARITY] && chk.cfg[BIT_UP_DIS]
                && chk.cfg[BIT_LO_DIS]); // RULE13
        end else begin
            chk.viol = isProt; // RULE12
        end
    end
endmodule : flash_prot_check
`default_nettype wire

// File: src/flash_protect_reset_irq_ctrl.sv
/*
 * flash control: ahb-lite registers, reset byte load, command dispatch.
 * assumes an array engine on clk_sys; specialMode is an async pin.
 */
// The implementer's own choices: register access over AHB-Lite and the address map.
// Behaviour
// (RULE1) address buffer reads zero in normal modes
// (RULE2) sector erase ignores address bits 8..0
// (RULE3) mass erase accepts any array address
// (RULE4) data buffer zero normally, writable special
// (RULE5) factory register ignores user reads, writes
// (RULE6) reset sequence holds cpu, loads bytes
// (RULE7) reset aborts any running flash command
// (RULE8) buffer-empty flag with enable raises interrupt
// (RULE9) commands-complete flag with enable raises interrupt
// (RULE10) protection byte loaded from address FF0D
// (RULE11) software unprotects upper sector before reprogramming
// (RULE12) protected program or erase sets violation
// (RULE13) mass erase needs polarity, both disables set
// (RULE14) polarity bit inverts meaning of disables
// (RULE15) software leaves spare bit six erased
// (RULE16) upper disable bit five gates upper area
// (RULE17) upper size writable only while disabled
// (RULE18) lower disable bit two gates lower area
// (RULE19) lower size writable only while disabled
// (RULE20) writing one to buffer-empty launches command
// (RULE21) complete flag waits for all commands
// (RULE22) interrupt is or of enabled sources
`timescale 1ns/100ps
`default_nettype none
module flash_protect_reset_irq_ctrl
    import flash_ctrl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic specialMode,
    output logic cpuHold,
    output logic irqReq,
    output logic nvmRdReq,
    output logic [ADDR_W-1:0] nvmRdAddr,
    input wire logic [7:0] nvmRdData,
    input wire logic nvmRdValid,
    output logic nvmCmdStart,
    output logic [7:0] nvmCmdCode,
    output logic [ADDR_W-1:0] nvmCmdAddr,
    output logic [DATA_W-1:0] nvmCmdData,
    output logic nvmCmdAbort,
    input wire logic nvmCmdDone
);
    prot_check_if chk ();

    flash_prot_check u_check (
        .chk(chk.judge)
    );

    seq_state_t state_reg, state_next;
    logic modeSync1_reg, modeSync2_reg;
    logic wrPend_reg, wrPend_next;
    logic [OFS_W-1:0] wrOfs_reg, wrOfs_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic hreadyout_reg, hreadyout_next;
    logic [7:0] protection_config_reg, protection_config_next;
    logic [7:0] security_config_reg, security_config_next;
    logic buffers_empty_irq_en_reg, buffers_empty_irq_en_next;
    logic cmds_complete_irq_en_reg, cmds_complete_irq_en_next;
    logic buffers_empty_flag_reg, buffers_empty_flag_next;
    logic cmds_complete_flag_reg, cmds_complete_flag_next;
    logic protect_violation_flag_reg, protect_violation_flag_next;
    logic [ADDR_W-1:0] captured_address_reg, captured_address_next;
    logic [DATA_W-1:0] captured_data_reg, captured_data_next;
    logic [7:0] cmdBuf_reg, cmdBuf_next;
    logic bufFull_reg, bufFull_next;
    logic activeBusy_reg, activeBusy_next;
    logic cpuHold_reg, cpuHold_next;
    logic irqReq_reg, irqReq_next;
    logic nvmRdReq_reg, nvmRdReq_next;
    logic [ADDR_W-1:0] nvmRdAddr_reg, nvmRdAddr_next;
    logic nvmCmdStart_reg, nvmCmdStart_next;
    logic [7:0] nvmCmdCode_reg, nvmCmdCode_next;
    logic [ADDR_W-1:0] nvmCmdAddr_reg, nvmCmdAddr_next;
    logic [DATA_W-1:0] nvmCmdData_reg, nvmCmdData_next;
    logic nvmCmdAbort_reg, nvmCmdAbort_next;

    logic addrPhase;
    logic wrDone;
    logic running;
    logic launch;
    logic dispatch;
    logic [ADDR_W-1:0] wrArrayAddr;

    assign addrPhase = hsel && htrans[1] && hready;
    assign running = state_reg == ST_RUN;
    assign wrDone = wrPend_reg && running;
    assign wrArrayAddr = hwdata[31:16];
    assign launch = wrDone && wrOfs_reg == OFS_STATUS
        && hwdata[BIT_BUF_EMPTY] && buffers_empty_flag_reg; // RULE20
    assign dispatch = running && bufFull_reg && !activeBusy_reg;

    // checker sees the buffered command, sector address trimmed
    assign chk.cfg = protection_config_reg;
    assign chk.mass = cmdBuf_reg == CMD_MASS_ERASE;
    assign chk.addr = (cmdBuf_reg == CMD_SECT_ERASE)
        ? (captured_address_reg & SECTOR_MASK) // RULE2
        : captured_address_reg;

    always_comb begin
        state_next = state_reg;
        wrPend_next = 1'b0;
        wrOfs_next = wrOfs_reg;
        hrdata_next = hrdata_reg;
        hreadyout_next = 1'b1;
        protection_config_next = protection_config_reg;
        security_config_next = security_config_reg;
        buffers_empty_irq_en_next = buffers_empty_irq_en_reg;
        cmds_complete_irq_en_next = cmds_complete_irq_en_reg;
        buffers_empty_flag_next = buffers_empty_flag_reg;
        cmds_complete_flag_next = cmds_complete_flag_reg;
        protect_violation_flag_next = protect_violation_flag_reg;
        captured_address_next = captured_address_reg;
        captured_data_next = captured_data_reg;
        cmdBuf_next = cmdBuf_reg;
        bufFull_next = bufFull_reg;
        activeBusy_next = activeBusy_reg;
        nvmRdReq_next = 1'b0;
        nvmRdAddr_next = nvmRdAddr_reg;
        nvmCmdStart_next = 1'b0;
        nvmCmdCode_next = nvmCmdCode_reg;
        nvmCmdAddr_next = nvmCmdAddr_reg;
        nvmCmdData_next = nvmCmdData_reg;
        nvmCmdAbort_next = nvmCmdAbort_reg;
        unique case (state_reg)
            ST_RESET: begin
                nvmRdReq_next = 1'b1;
                nvmRdAddr_next = PROT_BYTE_ADDR; // RULE10
                state_next = ST_LOAD_PROT;
            end
            ST_LOAD_PROT: begin
                if (nvmRdValid) begin
                    protection_config_next = nvmRdData; // RULE10
                    nvmRdReq_next = 1'b1;
                    nvmRdAddr_next = SEC_BYTE_ADDR;
                    state_next = ST_LOAD_SEC;
                end
            end
            ST_LOAD_SEC: begin
                if (nvmRdValid) begin
                    security_config_next = nvmRdData; // RULE6
                    nvmCmdAbort_next = 1'b0;
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin end
        endcase
        cpuHold_next = state_next != ST_RUN; // RULE6
        // reads wait one cycle for registered data
        if (addrPhase) begin
            wrOfs_next = haddr[OFS_W-1:0];
            if (hwrite) begin
                wrPend_next = 1'b1;
            end else begin
                hreadyout_next = 1'b0;
            end
        end
        if (!hreadyout_reg) begin
            unique case (wrOfs_reg)
                OFS_CONFIG: hrdata_next = {24'h000000, buffers_empty_irq_en_reg,
                    cmds_complete_irq_en_reg, 6'h00};
                OFS_PROT: hrdata_next = {24'h000000, protection_config_reg};
                OFS_STATUS: hrdata_next = {24'h000000, buffers_empty_flag_reg,
                    cmds_complete_flag_reg, protect_violation_flag_reg, 5'h00};
                OFS_CMD: hrdata_next = {24'h000000, cmdBuf_reg};
                OFS_ADDR: hrdata_next = modeSync2_reg
                    ? {16'h0000, captured_address_reg} : '0; // RULE1
                OFS_DATA: hrdata_next = modeSync2_reg
                    ? {16'h0000, captured_data_reg} : '0; // RULE4
                OFS_SEC: hrdata_next = {24'h000000, security_config_reg};
                OFS_FACTORY: hrdata_next = '0; // RULE5
                default: hrdata_next = '0;
            endcase
        end
        if (wrDone) begin
            unique case (wrOfs_reg)
                OFS_CONFIG: begin
                    buffers_empty_irq_en_next = hwdata[BIT_BUF_EMPTY_IE];
                    cmds_complete_irq_en_next = hwdata[BIT_CMD_DONE_IE];
                end
                OFS_PROT: begin
                    protection_config_next[BIT_POLARITY] = hwdata[BIT_POLARITY];
                    protection_config_next[BIT_SPARE] = hwdata[BIT_SPARE];
                    protection_config_next[BIT_UP_DIS] = hwdata[BIT_UP_DIS];
                    protection_config_next[BIT_LO_DIS] = hwdata[BIT_LO_DIS];
                    if (protection_config_reg[BIT_UP_DIS]) begin
                        protection_config_next[BIT_UP_SIZE_HI:BIT_UP_SIZE_LO]
                            = hwdata[BIT_UP_SIZE_HI:BIT_UP_SIZE_LO]; // RULE17
                    end
                    if (protection_config_reg[BIT_LO_DIS]) begin
                        protection_config_next[BIT_LO_SIZE_HI:BIT_LO_SIZE_LO]
                            = hwdata[BIT_LO_SIZE_HI:BIT_LO_SIZE_LO]; // RULE19
                    end
                end
                OFS_STATUS: begin
                    if (hwdata[BIT_PROTECT_VIOLATION_FLAG]) begin
                        protect_violation_flag_next = 1'b0;
                    end
                end
                OFS_CMD: cmdBuf_next = hwdata[7:0];
                OFS_ADDR: begin
                    if (modeSync2_reg) begin
                        captured_address_next = hwdata[ADDR_W-1:0]; // RULE1
                    end
                end
                OFS_DATA: begin
                    if (modeSync2_reg && captured_address_reg >= FLASH_LO)
                    begin
                        captured_data_next = hwdata[DATA_W-1:0]; // RULE4
                    end
                end
                OFS_ARRAY_WR: begin
                    if (wrArrayAddr >= FLASH_LO) begin // RULE3
                        captured_address_next = wrArrayAddr;
                        captured_data_next = hwdata[DATA_W-1:0];
                    end
                end
                default: begin end // RULE5
            endcase
        end
        if (launch) begin
            bufFull_next = 1'b1;
            buffers_empty_flag_next = 1'b0; // RULE20
        end
        if (activeBusy_reg && nvmCmdDone) begin
            activeBusy_next = 1'b0;
        end
        if (dispatch) begin
            bufFull_next = 1'b0;
            buffers_empty_flag_next = 1'b1; // RULE20
            if (chk.viol) begin
                protect_violation_flag_next = 1'b1; // RULE12 RULE13
            end else begin
                activeBusy_next = 1'b1;
                nvmCmdStart_next = 1'b1;
                nvmCmdCode_next = cmdBuf_reg;
                nvmCmdAddr_next = chk.addr;
                nvmCmdData_next = captured_data_reg;
            end
        end
        if (launch) begin
            cmds_complete_flag_next = 1'b0; // RULE20
        end else if (running && !bufFull_next && !activeBusy_next) begin
            cmds_complete_flag_next = 1'b1; // RULE21
        end
        // cpu applies its global mask to this request
        irqReq_next = (buffers_empty_flag_next && buffers_empty_irq_en_next)
            || (cmds_complete_flag_next
            && cmds_complete_irq_en_next); // RULE8 RULE9 RULE22
    end

    always_ff @(posedge clk_sys) begin
        modeSync1_reg <= specialMode;
        modeSync2_reg <= modeSync1_reg;
        if (!rst_n) begin
            state_reg <= ST_RESET; // RULE6
            wrPend_reg <= 1'b0;
            wrOfs_reg <= '0;
            hrdata_reg <= 32'h00000000;
            hreadyout_reg <= 1'b1;
            protection_config_reg <= PROT_RST;
            security_config_reg <= SEC_RST;
            buffers_empty_irq_en_reg <= 1'b0;
            cmds_complete_irq_en_reg <= 1'b0;
            buffers_empty_flag_reg <= 1'b1;
            cmds_complete_flag_reg <= 1'b1;
            protect_violation_flag_reg <= 1'b0;
            captured_address_reg <= '0;
            captured_data_reg <= '0;
            cmdBuf_reg <= CMD_RST;
            bufFull_reg <= 1'b0;
            activeBusy_reg <= 1'b0;
            cpuHold_reg <= 1'b1;
            irqReq_reg <= 1'b0;
            nvmRdReq_reg <= 1'b0;
            nvmRdAddr_reg <= '0;
            nvmCmdStart_reg <= 1'b0;
            nvmCmdCode_reg <= CMD_RST;
            nvmCmdAddr_reg <= '0;
            nvmCmdData_reg <= '0;
            nvmCmdAbort_reg <= 1'b1; // RULE7
        end else begin
            state_reg <= state_next;
            wrPend_reg <= wrPend_next;
            wrOfs_reg <= wrOfs_next;
            hrdata_reg <= hrdata_next;
            hreadyout_reg <= hreadyout_next;
            protection_config_reg <= protection_config_next;
            security_config_reg <= security_config_next;
            buffers_empty_irq_en_reg <= buffers_empty_irq_en_next;
            cmds_complete_irq_en_reg <= cmds_complete_irq_en_next;
            buffers_empty_flag_reg <= buffers_empty_flag_next;
            cmds_complete_flag_reg <= cmds_complete_flag_next;
            protect_violation_flag_reg <= protect_violation_flag_next;
            captured_address_reg <= captured_address_next;
            captured_data_reg <= captured_data_next;
            cmdBuf_reg <= cmdBuf_next;
            bufFull_reg <= bufFull_next;
            activeBusy_reg <= activeBusy_next;
            cpuHold_reg <= cpuHold_next;
            irqReq_reg <= irqReq_next;
            nvmRdReq_reg <= nvmRdReq_next;
            nvmRdAddr_reg <= nvmRdAddr_next;
            nvmCmdStart_reg <= nvmCmdStart_next;
            nvmCmdCode_reg <= nvmCmdCode_next;
            nvmCmdAddr_reg <= nvmCmdAddr_next;
            nvmCmdData_reg <= nvmCmdData_next;
            nvmCmdAbort_reg <= nvmCmdAbort_next;
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;
    assign cpuHold = cpuHold_reg;
    assign irqReq = irqReq_reg;
    assign nvmRdReq = nvmRdReq_reg;
    assign nvmRdAddr = nvmRdAddr_reg;
    assign nvmCmdStart = nvmCmdStart_reg;
    assign nvmCmdCode = nvmCmdCode_reg;
    assign nvmCmdAddr = nvmCmdAddr_reg;
    assign nvmCmdData = nvmCmdData_reg;
    assign nvmCmdAbort = nvmCmdAbort_reg;
endmodule : flash_protect_reset_irq_ctrl
`default_nettype wire

// File: verification/flash_array_model.sv
/*
 * array engine model: answers byte reads and commands after a delay.
 * assumes the control block on clk_sys with pulse handshakes.
 */
`timescale 1ns/100ps
`default_nettype none
module flash_array_model
    import flash_ctrl_pkg::*;
#(
    parameter logic [7:0] PROT_INIT = 8'hFE,
    parameter logic [7:0] SEC_INIT = 8'hA5
)
(
    input wire logic clk_sys,
    input wire logic slow,
    input wire logic nvmRdReq,
    input wire logic [ADDR_W-1:0] nvmRdAddr,
    output var logic [7:0] nvmRdData = 8'h00,
    output var logic nvmRdValid = 1'b0,
    input wire logic nvmCmdStart,
    input wire logic nvmCmdAbort,
    output var logic nvmCmdDone = 1'b0
);
    int rdCnt = 0;
    int cmdCnt = 0;
    wire logic [7:0] rdByte = (nvmRdAddr === PROT_BYTE_ADDR) ? PROT_INIT
        : SEC_INIT;
    always @(posedge clk_sys) begin
        nvmRdValid <= 1'b0;
        nvmCmdDone <= 1'b0;
        // released data lines toggle each cycle, so the stale byte shows again on alternate cycles
        nvmRdData <= ~nvmRdData;
        if (nvmRdReq) begin
            rdCnt <= slow ? 9 : 2;
        end else if (rdCnt > 1) begin
            rdCnt <= rdCnt - 1;
        end else if (rdCnt == 1) begin
            rdCnt <= 0;
            nvmRdData <= rdByte;
            nvmRdValid <= 1'b1;
        end
        if (nvmCmdAbort) begin
            cmdCnt <= 0;
        end else if (nvmCmdStart) begin
            cmdCnt <= slow ? 40 : 12;
        end else if (cmdCnt > 1) begin
            cmdCnt <= cmdCnt - 1;
        end else if (cmdCnt == 1) begin
            cmdCnt <= 0;
            nvmCmdDone <= 1'b1;
        end
    end
endmodule : flash_array_model
`default_nettype wire

// File: verification/flash_ctrl_sva.sv
/*
 * port assertions for the flash control block.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none
module flash_ctrl_sva
    import flash_ctrl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic cpuHold,
    input wire logic irqReq,
    input wire logic nvmRdReq,
    input wire logic [ADDR_W-1:0] nvmRdAddr,
    input wire logic nvmRdValid,
    input wire logic nvmCmdStart,
    input wire logic [7:0] nvmCmdCode,
    input wire logic [ADDR_W-1:0] nvmCmdAddr,
    input wire logic nvmCmdAbort
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_read_wait: assert property (
        hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (
        hsel && htrans[1] && hready && hwrite |=> hreadyout && !hresp)
        else $error("write stalled or refused");
    a_hold_release: assert property (
        $rose(rst_n) |-> cpuHold && nvmCmdAbort)
        else $error("no hold after reset");
    a_first_fetch: assert property (
        $rose(rst_n) |-> ##[0:2] (nvmRdReq && nvmRdAddr == PROT_BYTE_ADDR))
        else $error("protection byte not fetched first");
    a_hold_end: assert property (
        $fell(cpuHold) |-> $past(nvmRdValid))
        else $error("hold ended without array answer");
    a_abort_level: assert property (
        nvmCmdAbort == cpuHold)
        else $error("abort and hold disagree");
    a_no_start_hold: assert property (
        cpuHold |-> !nvmCmdStart && !irqReq)
        else $error("activity during hold");
    a_sector_align: assert property (
        nvmCmdStart && nvmCmdCode == CMD_SECT_ERASE
            |-> nvmCmdAddr[8:0] == 9'h000)
        else $error("sector address low bits kept");
    a_start_pulse: assert property (
        nvmCmdStart |=> !nvmCmdStart)
        else $error("start not a pulse");
    a_rd_pulse: assert property (
        nvmRdReq |=> !nvmRdReq)
        else $error("read request not a pulse");
endmodule : flash_ctrl_sva
bind flash_protect_reset_irq_ctrl flash_ctrl_sva flash_ctrl_sva_inst (.*);
`default_nettype wire

// File: verification/flash_protect_reset_irq_ctrl_bench.sv
/*
 * bench for the flash control block: register rows, protection rows,
 * buffered commands, reset abort. assumes hready tied to hreadyout.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin numErrors++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module flash_protect_reset_irq_ctrl_bench
    import flash_ctrl_pkg::*;
;
    logic clk_sys = 0, rst_n = 0, hsel = 0, hwrite = 0, mode = 0, slow = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [1:0] htrans = 0;
    wire logic [31:0] hrdata;
    wire logic hready, hresp, cpuHold, irqReq, rdReq, rdValid, start, abort;
    wire logic done;
    wire logic [7:0] rdData, code;
    wire logic [15:0] rdAddr, cmdAddr;
    int numErrors = 0, testsRun = 0, starts = 0, s0, n;
    logic [15:0] lastAddr, expA;
    typedef struct {logic [7:0] o; logic [31:0] e0, w, e1;} reg_row_t;
    typedef struct {logic [7:0] w, rb, c; logic [15:0] a; logic v;} prot_row_t;
    reg_row_t rows[8] = '{'{OFS_STATUS, 32'hC0, 32'h0, 32'hC0},
        '{OFS_ADDR, 32'h0, 32'h8123, 32'h0},
        '{OFS_DATA, 32'h0, 32'hBEEF, 32'h0},
        '{OFS_FACTORY, 32'h0, 32'h55, 32'h0}, '{OFS_SEC, 32'hA5, 32'h0, 32'hA5},
        '{OFS_PROT, 32'hFE, 32'hFF, 32'hFF}, '{8'h40, 32'h0, 32'h77, 32'h0},
        '{OFS_CONFIG, 32'h0, 32'hC0, 32'hC0}};
    prot_row_t pRows[8] = '{'{8'h7F, 8'h7F, 8'h20, 16'h9000, 1'b1},
        '{8'h78, 8'h78, 8'h40, 16'h81AB, 1'b0},
        '{8'h7B, 8'h78, 8'h20, 16'h8200, 1'b1},
        '{8'hFF, 8'hFC, 8'h20, 16'h9001, 1'b0},
        '{8'hC7, 8'hC7, 8'h20, 16'hF900, 1'b1},
        '{8'hFF, 8'hE7, 8'h20, PROT_BYTE_ADDR, 1'b0},
        '{8'h7F, 8'h7F, 8'h41, 16'hC123, 1'b1},
        '{8'hFF, 8'hFF, 8'h41, 16'hC123, 1'b0}};
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (start) begin
            starts <= starts + 1;
            lastAddr <= cmdAddr;
        end
    end
    flash_protect_reset_irq_ctrl flash_protect_reset_irq_ctrl_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .specialMode(mode), .cpuHold(cpuHold), .irqReq(irqReq),
        .nvmRdReq(rdReq), .nvmRdAddr(rdAddr), .nvmRdData(rdData),
        .nvmRdValid(rdValid), .nvmCmdStart(start), .nvmCmdCode(code),
        .nvmCmdAddr(cmdAddr), .nvmCmdData(), .nvmCmdAbort(abort),
        .nvmCmdDone(done));
    flash_array_model flash_array_model_inst (.clk_sys(clk_sys), .slow(slow),
        .nvmRdReq(rdReq), .nvmRdAddr(rdAddr), .nvmRdData(rdData),
        .nvmRdValid(rdValid), .nvmCmdStart(start), .nvmCmdAbort(abort),
        .nvmCmdDone(done));
    task automatic reportAndStop();
        $display("mismatches %0d of %0d checks", numErrors, testsRun);
        if (numErrors == 0 && testsRun > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : reportAndStop
    task automatic hang();
        numErrors++;
        reportAndStop();
    endtask : hang
    task automatic bus(input logic w, input logic [7:0] o,
        input logic [31:0] d);
        int k;
        k = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, o};
        do @(posedge clk_sys); while (!hready && ++k < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (!hready && ++k < 50);
        rd = hrdata;
        if (k >= 50) hang();
    endtask : bus
    task automatic launch(input logic [7:0] c, input logic [15:0] a);
        bus(1, OFS_ARRAY_WR, {a, 16'h1234});
        bus(1, OFS_CMD, {24'h0, c});
        bus(1, OFS_STATUS, 32'h80);
    endtask : launch
    task automatic waitDone();
        n = 0;
        do bus(0, OFS_STATUS, 0); while (rd[6] !== 1'b1 && ++n < 100);
        if (n >= 100) hang();
    endtask : waitDone
    task automatic waitRun();
        for (n = 0; cpuHold !== 1'b0 && n < 200; n++) @(posedge clk_sys);
        if (n >= 200) hang();
    endtask : waitRun
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        waitRun();
        foreach (rows[i]) begin
            bus(0, rows[i].o, 0);
            `CHK(rd, rows[i].e0)
            bus(1, rows[i].o, rows[i].w);
            bus(0, rows[i].o, 0);
            `CHK(rd, rows[i].e1)
        end
        for (int i = 0; i < 3; i++) begin
            bus(1, OFS_CONFIG, 32'h80 >> i);
            repeat (2) @(posedge clk_sys);
            `CHK(irqReq, (i < 2))
        end
        mode <= 1'b1;
        repeat (3) @(posedge clk_sys);
        bus(1, OFS_ARRAY_WR, 32'h9345_1234);
        bus(0, OFS_ADDR, 0);
        `CHK(rd[15:0], 16'h9345)
        bus(1, OFS_DATA, 32'hBEEF);
        bus(0, OFS_DATA, 0);
        `CHK(rd[15:0], 16'hBEEF)
        mode <= 1'b0;
        s0 = starts;
        launch(CMD_PROGRAM, 16'h9000);
        launch(CMD_PROGRAM, 16'h9002);
        bus(0, OFS_STATUS, 0);
        `CHK(rd[6], 1'b0)
        waitDone();
        `CHK(starts - s0, 2)
        foreach (pRows[i]) begin
            s0 = starts;
            bus(1, OFS_PROT, {24'h0, pRows[i].w});
            bus(0, OFS_PROT, 0);
            `CHK(rd[7:0], pRows[i].rb)
            launch(pRows[i].c, pRows[i].a);
            waitDone();
            `CHK(rd[5], pRows[i].v)
            `CHK(starts - s0, int'(!pRows[i].v))
            expA = pRows[i].c == CMD_SECT_ERASE ? pRows[i].a & SECTOR_MASK
                : pRows[i].a;
            if (!pRows[i].v) `CHK(lastAddr, expA)
            bus(1, OFS_STATUS, 32'h20);
        end
        slow <= 1'b1;
        s0 = starts;
        launch(CMD_PROGRAM, 16'h9004);
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        `CHK({abort, cpuHold}, 2'b11)
        rst_n <= 1'b1;
        bus(1, OFS_CONFIG, 32'hC0);
        waitRun();
        bus(0, OFS_CONFIG, 0);
        `CHK(rd, 32'h0)
        waitDone();
        `CHK(starts - s0, 1)
        reportAndStop();
    end
endmodule : flash_protect_reset_irq_ctrl_bench
`default_nettype wire
